// ### hw/cpu_register_file_flags.sv
// Purpose: CPU register set with banking, wide views and flag register
// Assumes: Decode/ALU drives core ports; software uses AHB-Lite
// Notes:   Core write wins over bus write on the same register
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_defs.svh"

module cpu_register_file_flags (
  input  wire logic                    hclk,       // Bus clock
  input  wire logic                    hresetn,    // Async reset, low
  input  wire logic                    hsel,       // Slave select
  input  wire logic [11:0]             haddr,      // Byte address
  input  wire logic [1:0]              htrans,     // Transfer type
  input  wire logic                    hwrite,     // Write access
  input  wire logic [2:0]              hsize,      // Transfer size
  input  wire logic [31:0]             hwdata,     // Write data
  input  wire logic                    hready,     // Bus ready in
  output logic      [31:0]             hrdata,     // Read data
  output logic                         hreadyout,  // Always ready
  output logic                         hresp,      // Always OKAY
  input  wire cpu_regs_pkg::reg_sel_t  rd_a_sel,   // Read port A select
  input  wire cpu_regs_pkg::wr_size_t  rd_a_size,  // Read port A view
  output logic      [31:0]             rd_a_data,  // Read port A data
  input  wire cpu_regs_pkg::reg_wr_t   core_wr,    // Core register write
  input  wire cpu_regs_pkg::alu_upd_t  alu_upd,    // Flag update from ALU
  input  wire logic                    pc_load,    // Load next PC
  input  wire logic [19:0]             pc_next,    // Next instruction addr
  input  wire logic                    flg_wr,     // Core writes flags
  input  wire logic [10:0]             flg_wdata,  // Flag write value
  input  wire cpu_regs_pkg::int_ack_t  int_ack,    // Interrupt acceptance
  input  wire logic                    irq_req,    // Maskable request
  input  wire logic [2:0]              irq_lvl,    // Request priority
  output logic                         irq_take,   // Request may be taken
  output logic      [10:0]             flags,      // Flag register view
  output logic      [15:0]             sp_active,  // Selected stack ptr
  output logic      [19:0]             pc_out      // Program counter
);

  logic [15:0] usp_q, isp_q, sb_q;
  logic [19:0] vtb_q, pc_q;
  logic [10:0] flg_q;

  logic        ap_wr_q;
  logic [11:0] ap_addr_q;

  wire  bsel  = flg_q[`FLG_B];
  wire  usel  = flg_q[`FLG_U];
  wire  [2:0] processor_priority_level = flg_q[`FLG_IPL_HI:`FLG_IPL_LO];

  wire  ap_take = hsel & hready & htrans[1];
  wire  bus_wr  = ap_wr_q;
  wire  int_any = int_ack.hw_ack | int_ack.sw_int;
  wire  u_clr   = int_ack.hw_ack |
                  (int_ack.sw_int && int_ack.sw_vec <= `SWI_U_MAX);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture; single-cycle data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 12'h000;
    end
    else
    begin
      ap_wr_q   <= ap_take & hwrite;
      ap_addr_q <= haddr;
    end
  end

  // Bus write to a register index: map address to selector
  function automatic logic [4:0] bus_index(input logic [11:0] a);
    logic [4:0] r;
    r = 5'h1f;
    unique case (a)
      `OFS_R0:    r = 5'h00;
      `OFS_R1:    r = 5'h01;
      `OFS_R2:    r = 5'h02;
      `OFS_R3:    r = 5'h03;
      `OFS_A0:    r = 5'h04;
      `OFS_A1:    r = 5'h05;
      `OFS_FB:    r = 5'h06;
      `OFS_USP:   r = 5'h07;
      `OFS_ISP:   r = 5'h08;
      `OFS_SB:    r = 5'h09;
      `OFS_VTB:   r = 5'h0b;
      `OFS_FLG:   r = 5'h0c;
      `OFS_SP:    r = 5'h0a;
      `OFS_W_DLO: r = 5'h10;
      `OFS_W_DHI: r = 5'h11;
      `OFS_W_ADR: r = 5'h12;
      default:    r = 5'h1f;
    endcase
    return r;
  endfunction : bus_index

  wire [4:0] bidx = bus_index(ap_addr_q);

  // Per-register next values: core port first, bus second
  function automatic logic [15:0] upd16(input logic [15:0] cur,
    input cpu_regs_pkg::wr_size_t sz, input logic [15:0] d);
    logic [15:0] r;
    unique case (sz)
      cpu_regs_pkg::W_LO8: r = {cur[15:8], d[7:0]};
      cpu_regs_pkg::W_HI8: r = {d[7:0], cur[7:0]};
      default:             r = d;
    endcase
    return r;
  endfunction : upd16

  // Core write hit tests, including the 32-bit pairs
  wire cw = core_wr.en;
  wire [3:0] cs = core_wr.sel;
  wire w32 = core_wr.size == cpu_regs_pkg::W_32;
  wire [15:0] cd_lo = core_wr.data[15:0];
  wire [15:0] cd_hi = core_wr.data[31:16];

  logic [15:0] bank_val [0:6];

  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_bank
      // Pair partner: R2 is upper of R0, R3 upper of R1, A1 upper of A0
      wire lo_of_pair = w32 && (g == 0 || g == 1 || g == 4) && cs == g;
      wire hi_of_pair = w32 && ((g == 2 && cs == 0) ||
                                (g == 3 && cs == 1) ||
                                (g == 5 && cs == 4));
      wire core_hit   = cw && ((cs == g && !w32) || lo_of_pair ||
                               hi_of_pair);
      wire bus_hit    = bus_wr && (bidx == g ||
                        (bidx == 5'h10 && (g == 0 || g == 2)) ||
                        (bidx == 5'h11 && (g == 1 || g == 3)) ||
                        (bidx == 5'h12 && (g == 4 || g == 5)));
      wire bus_hi     = (bidx != g) && (g == 2 || g == 3 || g == 5);
      wire [15:0] cval = hi_of_pair ? cd_hi : cd_lo;
      wire [15:0] bval = bus_hi ? hwdata[31:16] : hwdata[15:0];
      wire bytes_ok   = (g < 2) && !w32;
      wire bank_hit   = core_hit | bus_hit;
      logic [15:0] bk_q [0:1];
      logic [15:0] nxt_d;
      always_comb
      begin
        if (core_hit)
          nxt_d = upd16(bk_q[bsel],
            bytes_ok ? core_wr.size : cpu_regs_pkg::W_16, cval);
        else
          nxt_d = bval;
      end
      // Only the selected bank is touched
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          bk_q[0] <= 16'h0000;
          bk_q[1] <= 16'h0000;
        end
        else if (bank_hit)
          bk_q[bsel] <= nxt_d;
      end
      assign bank_val[g] = bk_q[bsel];
    end
  endgenerate

  wire core_sp  = cw && cs == cpu_regs_pkg::SEL_SP;
  // Source chosen per register so a core write elsewhere keeps bus data
  wire usp_cw   = (cw && cs == cpu_regs_pkg::SEL_USP) || (core_sp && usel);
  wire isp_cw   = (cw && cs == cpu_regs_pkg::SEL_ISP) || (core_sp && !usel);
  wire sb_cw    = cw && cs == cpu_regs_pkg::SEL_SB;
  wire vtb_cw   = cw && cs == cpu_regs_pkg::SEL_VTB;
  wire usp_hit  = usp_cw ||
                  (bus_wr && (bidx == 5'h07 || (bidx == 5'h0a && usel)));
  wire isp_hit  = isp_cw ||
                  (bus_wr && (bidx == 5'h08 || (bidx == 5'h0a && !usel)));
  wire sb_hit   = sb_cw || (bus_wr && bidx == 5'h09);
  wire vtb_hit  = vtb_cw || (bus_wr && bidx == 5'h0b);

  // Shared registers, not banked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      usp_q <= 16'h0000;
      isp_q <= 16'h0000;
      sb_q  <= 16'h0000;
      vtb_q <= 20'h00000;
      pc_q  <= 20'h00000;
    end
    else
    begin
      if (usp_hit)
        usp_q <= usp_cw ? core_wr.data[15:0] : hwdata[15:0];
      if (isp_hit)
        isp_q <= isp_cw ? core_wr.data[15:0] : hwdata[15:0];
      if (sb_hit)
        sb_q  <= sb_cw ? core_wr.data[15:0] : hwdata[15:0];
      if (vtb_hit)
        vtb_q <= vtb_cw ? core_wr.data[19:0] : hwdata[19:0];
      if (pc_load)
        pc_q  <= pc_next;
    end
  end

  // Flag next value; ALU and interrupt events override writes
  wire [31:0] res   = alu_upd.result;
  wire        z_new = alu_upd.res32 ? (res == 32'h0) :
                      alu_upd.res8  ? (res[7:0] == 8'h00) :
                                      (res[15:0] == 16'h0000);
  wire        s_new = alu_upd.res32 ? res[31] :
                      alu_upd.res8  ? res[7] : res[15];
  logic [10:0] flg_d;
  always_comb
  begin
    flg_d = flg_q;
    if (bus_wr && bidx == 5'h0c)
      flg_d = hwdata[10:0] & `FLG_RW_MASK;
    if (flg_wr)
      flg_d = flg_wdata & `FLG_RW_MASK;
    if (alu_upd.c_en)
      flg_d[`FLG_C] = alu_upd.c;
    if (alu_upd.zso_en)
    begin
      flg_d[`FLG_Z] = z_new;
      flg_d[`FLG_S] = s_new;
      flg_d[`FLG_O] = alu_upd.o;
    end
    if (int_any)
      flg_d[`FLG_I] = 1'b0;
    if (u_clr)
      flg_d[`FLG_U] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flg_q <= `FLG_RESET;
    else
      flg_q <= flg_d;
  end

  // Gate for maskable requests
  assign irq_take = irq_req & flg_q[`FLG_I] & (irq_lvl > processor_priority_level);

  assign flags     = flg_q;
  assign sp_active = usel ? usp_q : isp_q;
  assign pc_out    = pc_q;

  // Core read port with byte and wide views
  function automatic logic [15:0] rd16(input logic [3:0] s);
    logic [15:0] r;
    r = 16'h0000;
    if (s < 4'h7)
      r = bank_val[s[2:0]];
    else if (s == 4'h7)
      r = usp_q;
    else if (s == 4'h8)
      r = isp_q;
    else if (s == 4'h9)
      r = sb_q;
    else if (s == 4'ha)
      r = sp_active;
    else if (s == 4'hb)
      r = vtb_q[15:0];
    return r;
  endfunction : rd16

  logic [31:0] rd_a_d;
  wire  [15:0] rd_a_w = rd16(rd_a_sel);
  always_comb
  begin
    rd_a_d = {16'h0000, rd_a_w};
    unique case (rd_a_size)
      cpu_regs_pkg::W_LO8: rd_a_d = {24'h0, rd_a_w[7:0]};
      cpu_regs_pkg::W_HI8: rd_a_d = {24'h0, rd_a_w[15:8]};
      cpu_regs_pkg::W_32:
      begin
        if (rd_a_sel == cpu_regs_pkg::SEL_R0)
          rd_a_d = {bank_val[2], bank_val[0]};
        else if (rd_a_sel == cpu_regs_pkg::SEL_R1)
          rd_a_d = {bank_val[3], bank_val[1]};
        else if (rd_a_sel == cpu_regs_pkg::SEL_A0)
          rd_a_d = {bank_val[5], bank_val[4]};
        else if (rd_a_sel == cpu_regs_pkg::SEL_VTB)
          rd_a_d = {12'h000, vtb_q};
      end
      default: ;
    endcase
  end
  assign rd_a_data = rd_a_d;

  // Bus read mux, taken at address phase
  logic [31:0] rdata_d;
  wire  [4:0]  bidx_ap = bus_index(haddr);
  always_comb
  begin
    rdata_d = 32'h0;
    unique case (bidx_ap)
      5'h0b:   rdata_d = {12'h000, vtb_q};
      5'h0c:   rdata_d = {21'h0, flg_q};
      5'h10:   rdata_d = {bank_val[2], bank_val[0]};
      5'h11:   rdata_d = {bank_val[3], bank_val[1]};
      5'h12:   rdata_d = {bank_val[5], bank_val[4]};
      5'h1f:   rdata_d = (haddr == `OFS_PC) ? {12'h000, pc_q} : 32'h0;
      default: rdata_d = {16'h0000, rd16(bidx_ap[3:0])};
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (ap_take & !hwrite)
      hrdata <= rdata_d;
  end

  property p_int_clears_i;
    @(posedge hclk) disable iff (!hresetn)
    int_any |=> !flg_q[`FLG_I];
  endproperty
  a_int_clears_i: assert property (p_int_clears_i)
    else $error("I flag not cleared after interrupt");

  property p_u_clear;
    @(posedge hclk) disable iff (!hresetn)
    u_clr |=> !flg_q[`FLG_U];
  endproperty
  a_u_clear: assert property (p_u_clear)
    else $error("U flag not cleared");

  property p_take_level;
    @(posedge hclk) disable iff (!hresetn)
    irq_take |-> irq_lvl > flg_q[`FLG_IPL_HI:`FLG_IPL_LO] && flg_q[`FLG_I];
  endproperty
  a_take_level: assert property (p_take_level)
    else $error("Request taken at or below level");

  property p_zero;
    @(posedge hclk) disable iff (!hresetn)
    alu_upd.zso_en && !alu_upd.res32 && !alu_upd.res8 |=>
      flg_q[`FLG_Z] == ($past(alu_upd.result[15:0]) == 16'h0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("Zero flag wrong");

  property p_sign;
    @(posedge hclk) disable iff (!hresetn)
    alu_upd.zso_en && !alu_upd.res32 && !alu_upd.res8 |=>
      flg_q[`FLG_S] == $past(alu_upd.result[15]);
  endproperty
  a_sign: assert property (p_sign)
    else $error("Sign flag wrong");

  property p_carry_hold;
    @(posedge hclk) disable iff (!hresetn)
    !alu_upd.c_en && !flg_wr && !(bus_wr && bidx == 5'h0c) |=>
      $stable(flg_q[`FLG_C]);
  endproperty
  a_carry_hold: assert property (p_carry_hold)
    else $error("Carry changed without update");

  property p_sp_sel;
    @(posedge hclk) disable iff (!hresetn)
    core_wr.en && core_wr.sel == cpu_regs_pkg::SEL_SP && !u_clr |=>
      sp_active == $past(core_wr.data[15:0]);
  endproperty
  a_sp_sel: assert property (p_sp_sel)
    else $error("Wrong stack pointer active");

  property p_pc_load;
    @(posedge hclk) disable iff (!hresetn)
    pc_load |=> pc_out == $past(pc_next);
  endproperty
  a_pc_load: assert property (p_pc_load)
    else $error("PC not loaded");

endmodule : cpu_register_file_flags
`default_nettype wire

// ### pkg/cpu_regs_defs.svh
// Purpose: Constants for the CPU register set and its AHB-Lite view
// Assumes: 32-bit word per register, byte addresses
// Notes:   Flag register layout follows the usual 11-bit arrangement
`ifndef CPU_REGS_DEFS_SVH
`define CPU_REGS_DEFS_SVH

`define OFS_R0      12'h000
`define OFS_R1      12'h004
`define OFS_R2      12'h008
`define OFS_R3      12'h00c
`define OFS_A0      12'h010
`define OFS_A1      12'h014
`define OFS_FB      12'h018
`define OFS_VTB     12'h01c
`define OFS_PC      12'h020
`define OFS_USP     12'h024
`define OFS_ISP     12'h028
`define OFS_SB      12'h02c
`define OFS_FLG     12'h030
`define OFS_SP      12'h034
`define OFS_W_DLO   12'h038
`define OFS_W_DHI   12'h03c
`define OFS_W_ADR   12'h040

`define FLG_C       0
`define FLG_D       1
`define FLG_Z       2
`define FLG_S       3
`define FLG_B       4
`define FLG_O       5
`define FLG_I       6
`define FLG_U       7
`define FLG_IPL_LO  8
`define FLG_IPL_HI  10
`define FLG_RW_MASK 11'h7fd
`define FLG_RESET   11'h000
`define SWI_U_MAX   6'h1f

`endif

// ### pkg/cpu_regs_pkg.sv
// Purpose: Types for the CPU register set
// Assumes: Nothing beyond the constants header
// Notes:   Carriers for core-side write and flag update ports
package cpu_regs_pkg;

  typedef enum logic [3:0] {
    SEL_R0  = 4'h0,
    SEL_R1  = 4'h1,
    SEL_R2  = 4'h2,
    SEL_R3  = 4'h3,
    SEL_A0  = 4'h4,
    SEL_A1  = 4'h5,
    SEL_FB  = 4'h6,
    SEL_USP = 4'h7,
    SEL_ISP = 4'h8,
    SEL_SB  = 4'h9,
    SEL_SP  = 4'ha,
    SEL_VTB = 4'hb
  } reg_sel_t;

  typedef enum logic [1:0] {
    W_16   = 2'h0,
    W_LO8  = 2'h1,
    W_HI8  = 2'h2,
    W_32   = 2'h3
  } wr_size_t;

  typedef struct packed {
    logic        en;
    reg_sel_t    sel;
    wr_size_t    size;
    logic [31:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic c_en;
    logic c;
    logic zso_en;
    logic [31:0] result;
    logic        res32;
    logic        res8;
    logic o;
  } alu_upd_t;

  typedef struct packed {
    logic       hw_ack;
    logic       sw_int;
    logic [5:0] sw_vec;
  } int_ack_t;

endpackage : cpu_regs_pkg

// ### tb/core_model.sv
// Purpose: Stand-in for instruction decode and ALU driving the core side
// Assumes: One-cycle pulses except the held req level, driven by NBA just after a rising edge
// Notes:   Tasks return 1 ns after the landing edge so outputs settle
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input  wire logic                   hclk,      // Core clock
  output var  cpu_regs_pkg::reg_wr_t  core_wr,   // Register write
  output var  cpu_regs_pkg::alu_upd_t alu_upd,   // Flag update
  output var  cpu_regs_pkg::int_ack_t int_ack,   // Acceptance pulse
  output logic                        pc_load,   // PC load strobe
  output logic [19:0]                 pc_next,   // PC value
  output logic                        flg_wr,    // Flag write strobe
  output logic [10:0]                 flg_wdata, // Flag write value
  output logic                        irq_req,   // Request
  output logic [2:0]                  irq_lvl    // Request priority
);
  initial
  begin
    core_wr = '0;
    alu_upd = '0;
    int_ack = '0;
    pc_load = 1'b0;
    pc_next = 20'h00000;
    flg_wr = 1'b0;
    flg_wdata = 11'h000;
    irq_req = 1'b0;
    irq_lvl = 3'h0;
  end

  task automatic cw(input cpu_regs_pkg::reg_wr_t v);
    @(posedge hclk);
    core_wr <= v;
    @(posedge hclk);
    core_wr <= '0;
    #1;
  endtask : cw

  task automatic alu(input cpu_regs_pkg::alu_upd_t v);
    @(posedge hclk);
    alu_upd <= v;
    @(posedge hclk);
    alu_upd <= '0;
    #1;
  endtask : alu

  task automatic ack(input cpu_regs_pkg::int_ack_t v);
    @(posedge hclk);
    int_ack <= v;
    @(posedge hclk);
    int_ack <= '0;
    #1;
  endtask : ack

  // Debug bit kept low by the core itself, reserved places written 0
  task automatic fw(input logic [10:0] v);
    @(posedge hclk);
    flg_wdata <= v & 11'h7fd;
    flg_wr <= 1'b1;
    @(posedge hclk);
    flg_wr <= 1'b0;
    #1;
  endtask : fw

  task automatic pcl(input logic [19:0] v);
    @(posedge hclk);
    pc_next <= v;
    pc_load <= 1'b1;
    @(posedge hclk);
    pc_load <= 1'b0;
    #1;
  endtask : pcl

  task automatic req(input logic r, input logic [2:0] l);
    @(posedge hclk);
    irq_req <= r;
    irq_lvl <= l;
    #1;
  endtask : req
endmodule : core_model
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the CPU register set
// Assumes: AHB-Lite single word transfers; core side from core_model
// Notes:   Shared registers are mirrored into both model banks
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata, rd_a_data;
  logic        hreadyout, hresp, irq_take, pc_load, flg_wr, irq_req;
  logic [10:0] flags, flg_wdata;
  logic [15:0] sp_active;
  logic [19:0] pc_out, pc_next;
  logic [2:0]  irq_lvl;
  cpu_regs_pkg::reg_wr_t  core_wr;
  cpu_regs_pkg::alu_upd_t alu_upd;
  cpu_regs_pkg::int_ack_t int_ack;
  cpu_regs_pkg::reg_sel_t ra_sel = cpu_regs_pkg::SEL_R0;
  cpu_regs_pkg::wr_size_t ra_size = cpu_regs_pkg::W_16;
  int unsigned m[2][12] = '{default: 0};
  int unsigned fl = 0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #20 hclk = ~hclk;

  cpu_register_file_flags dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .rd_a_sel(ra_sel), .rd_a_size(ra_size),
    .rd_a_data, .core_wr, .alu_upd, .pc_load, .pc_next, .flg_wr,
    .flg_wdata, .int_ack, .irq_req, .irq_lvl, .irq_take, .flags,
    .sp_active, .pc_out);

  core_model core (.hclk, .core_wr, .alu_upd, .int_ack, .pc_load,
    .pc_next, .flg_wr, .flg_wdata, .irq_req, .irq_lvl);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic int unsigned mr(int i);
    int unsigned b;
    b = (fl >> 4) & 1;
    case (i)
      12: return fl;
      13: return ((fl >> 7) & 1) ? m[b][9] : m[b][10];
      14: return (m[b][2] << 16) | m[b][0];
      15: return (m[b][3] << 16) | m[b][1];
      16: return (m[b][5] << 16) | m[b][4];
      default: return (i < 12) ? m[b][i] : 0;
    endcase
  endfunction : mr

  // Index 8 is the read-only counter, 17 takes no bus writes and 13 is not modelled here
  task automatic mw(int i, int unsigned v);
    int unsigned b;
    b = (fl >> 4) & 1;
    case (i)
      7, 9, 10, 11:
      begin
        m[0][i] = v & ((i == 7) ? 32'hfffff : 32'hffff);
        m[1][i] = m[0][i];
      end
      12: fl = v & 32'h7fd;
      14, 15, 16:
      begin
        mw((i == 16) ? 4 : i - 14, v);
        mw((i == 16) ? 5 : i - 12, v >> 16);
      end
      default: if (i < 7) m[b][i] = v & 32'hffff;
    endcase
  endtask : mw

  task automatic bus(logic wr, int i, logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 12'(i * 4);
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(int i, int unsigned v);
    logic [31:0] d;
    bus(1'b1, i, v, d);
    mw(i, v);
  endtask : wr

  task automatic rdc(int i);
    logic [31:0] d;
    bus(1'b0, i, 32'h0, d);
    chk($sformatf("reg%0d", i), d, mr(i));
    chk("sp_active", {16'h0, sp_active}, mr(13));
    chk("rd_a_data", {16'h0, rd_a_data[15:0]}, mr(0));
  endtask : rdc

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    int unsigned r, b, q;
    int w;
    int vt[5] = '{0, 0, 31, 32, 63};
    logic [31:0] tv[6] = '{32'h0, 32'h80, 32'h8000, 32'h80000000,
                           32'h10000, 32'h100};
    cpu_regs_pkg::alu_upd_t u;
    void'($urandom(34472));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 18; i++) rdc(i);
    // Fill both banks, with wide, read-only and unmapped places in too
    for (int k = 0; k < 2; k++)
    begin
      wr(12, k << 4);
      for (int i = 0; i < 18; i++)
        if (i != 12 && i != 13) wr(i, $urandom);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(12, ((k & 1) << 4) | ((k >> 1) << 7));
      for (int i = 0; i < 18; i++) rdc(i);
    end
    r = $urandom & 32'hff;
    b = (fl >> 4) & 1;
    core.cw('{1'b1, cpu_regs_pkg::SEL_R0, cpu_regs_pkg::W_LO8, {4{r[7:0]}}});
    core.cw('{1'b1, cpu_regs_pkg::SEL_R1, cpu_regs_pkg::W_HI8, {4{r[7:0]}}});
    core.cw('{1'b1, cpu_regs_pkg::SEL_R3, cpu_regs_pkg::W_16, ~r});
    core.cw('{1'b1, cpu_regs_pkg::SEL_SP, cpu_regs_pkg::W_16, r << 4});
    m[b][0] = (m[b][0] & 32'hff00) | r;
    m[b][1] = (m[b][1] & 32'hff) | (r << 8);
    m[b][3] = ~r & 32'hffff;
    q = ((fl >> 7) & 1) ? 9 : 10;
    m[0][q] = (r << 4) & 32'hffff;
    m[1][q] = m[0][q];
    for (int i = 0; i < 4; i++) rdc(i);
    // Core read port: byte views and the R0 and A0 wide pairs
    for (int v = 0; v < 5; v++)
    begin
      @(posedge hclk);
      ra_size <= cpu_regs_pkg::wr_size_t'((v > 3) ? 3 : v);
      ra_sel <= (v == 2) ? cpu_regs_pkg::SEL_R1 :
                (v == 4) ? cpu_regs_pkg::SEL_A0 : cpu_regs_pkg::SEL_R0;
      @(posedge hclk);
      q = (v == 0) ? mr(0) : (v == 1) ? (mr(0) & 32'hff) :
          (v == 2) ? (mr(1) >> 8) : (v == 3) ? mr(14) : mr(16);
      chk("rd_a_view", rd_a_data, q);
    end
    @(posedge hclk);
    ra_size <= cpu_regs_pkg::W_16;
    ra_sel <= cpu_regs_pkg::SEL_R0;
    for (int k = 0; k < 24; k++)
    begin
      r = $urandom;
      u = '{r[0], r[1], k < 12 || r[2], (k < 12) ? tv[k % 6] : $urandom,
            r[3], r[4] & ~r[3], r[5]};
      if (u.c_en) fl = (fl & ~32'h1) | u.c;
      if (u.zso_en)
      begin
        w = u.res32 ? 32 : (u.res8 ? 8 : 16);
        q = u.result & 32'((64'h1 << w) - 1);
        fl = (fl & ~32'h2c) | (int'(q == 0) << 2) |
             (((q >> (w - 1)) & 1) << 3) | (int'(u.o) << 5);
      end
      core.alu(u);
      chk("flags", {21'h0, flags}, fl);
    end
    for (int p = 0; p < 16; p++)
    begin
      fl = ((p & 1) << 6) | ((p >> 1) << 8);
      core.fw(11'(fl));
      for (int l = 0; l < 8; l++)
      begin
        core.req(1'b1, 3'(l));
        chk("irq_take", {31'h0, irq_take}, (p & 1) && l > (p >> 1));
      end
      core.req(1'b0, 3'h7);
      chk("irq_take", {31'h0, irq_take}, 32'h0);
    end
    for (int j = 0; j < 5; j++)
    begin
      core.fw(11'h0c0);
      core.ack('{j == 0, j != 0, 6'(vt[j])});
      chk("flags_iu", {21'h0, flags & 11'h0c0},
          (j != 0 && vt[j] > 31) ? 32'h80 : 32'h0);
    end
    fl = 32'h080;
    r = $urandom & 32'hfffff;
    core.pcl(20'(r));
    m[0][8] = r;
    m[1][8] = r;
    chk("pc_out", {12'h0, pc_out}, r);
    rdc(8);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
